// ---- design/wsw_pkg.sv ----
// Constants, register map and state type of the window/standard watchdog
// What this block does
// - Type select low: window mode, closed then open
// - Type select high: standard timeout mode
// - Scale select high: period five times longer
// - Period from oscillator: resistor ohms times 0.5us
// - First open window after init: eight periods
// - Ratio low: open and closed halves
// - Ratio high: open is eight ninths
// - Open plus closed equals the period
// - Service during closed portion is a fault
// - Open portion expiring unserviced is a fault
// - Standard mode: service accepted any time
// - Standard mode: unserviced full period faults
// - Windows and hold timed in oscillator ticks
// - Fault drives output low one fifth period
// - Power good gates enable; else output released
// - Initialize on power, enable or fault-end edges
package wsw_pkg;
    // Clock and oscillator timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int OSC_TICK_PS = 500000;
    localparam int OSC_TICK_CYCLES = (OSC_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SERVICE_MIN_PS = 100000000;
    localparam int SERVICE_MIN_CYCLES = (SERVICE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Window arithmetic
    localparam int SCALE_FACTOR = 5;
    localparam int INIT_MULT = 8;
    localparam int HOLD_DIV = 5;
    localparam int RATIO_NUM = 8;
    localparam int RATIO_DEN = 9;
    localparam int HALF_DIV = 2;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] RATE_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] FAULTS_OFS = 8'h0C;

    // Control field positions and reset value
    localparam int CTRL_ENABLE_N_BIT = 0;
    localparam int CTRL_TYPE_BIT = 1;
    localparam int CTRL_SCALE_BIT = 2;
    localparam int CTRL_RATIO_BIT = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RESET = 4'h1;

    // Rate register: resistor value in ohms
    localparam int RATE_W = 24;
    localparam logic [23:0] RATE_RESET = 24'h004E20;

    // Status field positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_FAULT_DRIVE_BIT = 4;
    localparam int STAT_PIN_BIT = 5;
    localparam int STAT_PGOOD_BIT = 6;
    localparam int STAT_ENABLED_BIT = 7;

    typedef enum logic [2:0] {
        WSW_DISABLED,
        WSW_INIT_OPEN,
        WSW_OPEN,
        WSW_CLOSED,
        WSW_FAULT_HOLD
    } wsw_state_t;
endpackage

// ---- design/wsw_tick.sv ----
// Oscillator tick divider: one-cycle enable every CYCLES clocks
`timescale 1ns/1ps
module wsw_tick #(
    parameter int CYCLES = 125
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clear,
    output logic tick
);
    if (CYCLES < 1) begin : g_chk
        $error("wsw_tick: CYCLES must be at least one");
    end

    logic [15:0] count;
    logic [15:0] next_count;
    logic next_tick;

    // Clear realigns the phase so each window is whole ticks
    always_comb begin
        next_count = count + 16'h0001;
        next_tick = 1'b0;
        if (clear) begin
            next_count = 16'h0000;
        end else if (count >= 16'(CYCLES - 1)) begin
            next_count = 16'h0000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= 16'h0000;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule

// ---- design/wsw_top.sv ----
// Window/standard watchdog with APB register access
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module wsw_top
    import wsw_pkg::*;
#(
    parameter int TICK_CYCLES = OSC_TICK_CYCLES,
    parameter int CNT_W = 32
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic service_input,
    input wire logic power_good,
    input wire logic fault_output_in,
    output logic fault_output_out,
    output logic fault_output_oe
);
    // Tick divider counts in 16 bits
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_chk_tick
        $error("wsw_top: TICK_CYCLES must lie in 1 to 65535");
    end
    // Largest init window is rate times forty, which needs 30 bits
    if (CNT_W < 30 || CNT_W > 32) begin : g_chk_cnt
        $error("wsw_top: CNT_W must lie in 30 to 32");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [3:0] ctrl;
    logic [RATE_W-1:0] rate;
    logic [15:0] faults;
    logic [31:0] next_prdata;
    logic [3:0] next_ctrl;
    logic [RATE_W-1:0] next_rate;
    logic [15:0] next_faults;
    logic setup;
    logic access;
    logic mapped;
    logic [31:0] status_word;
    logic fault_event;
    wsw_state_t state;

    assign setup = psel && !penable;
    assign access = psel && penable;
    // No wait states: every register answers in its access cycle
    assign pready = 1'b1;
    assign mapped = (paddr == CTRL_OFS) || (paddr == RATE_OFS) ||
                    (paddr == STATUS_OFS) || (paddr == FAULTS_OFS);
    assign pslverr = access && !mapped;

    always_comb begin
        status_word = 32'h00000000;
        status_word[STAT_STATE_LSB +: 3] = state;
        status_word[STAT_FAULT_DRIVE_BIT] = fault_output_oe;
        status_word[STAT_PIN_BIT] = fault_output_in;
        status_word[STAT_PGOOD_BIT] = power_good;
        status_word[STAT_ENABLED_BIT] = power_good && !ctrl[CTRL_ENABLE_N_BIT];
    end

    // Read data captured in setup so it comes from a flop in access
    always_comb begin
        next_prdata = prdata;
        next_ctrl = ctrl;
        next_rate = rate;
        next_faults = faults;
        if (setup && !pwrite) begin
            case (paddr)
                CTRL_OFS: next_prdata = {28'h0000000, ctrl};
                RATE_OFS: next_prdata = {8'h00, rate};
                STATUS_OFS: next_prdata = status_word;
                FAULTS_OFS: next_prdata = {16'h0000, faults};
                default: next_prdata = 32'h00000000;
            endcase
        end
        // Status writes fall to the default and are dropped
        if (access && pwrite) begin
            case (paddr)
                CTRL_OFS: next_ctrl = pwdata[CTRL_W-1:0];
                RATE_OFS: next_rate = pwdata[RATE_W-1:0];
                default: next_ctrl = ctrl;
            endcase
        end
        // Saturates rather than wrapping
        if (fault_event && faults != 16'hFFFF) begin
            next_faults = faults + 16'h0001;
        end
        if (access && pwrite && paddr == FAULTS_OFS) begin
            next_faults = fault_event ? 16'h0001 : 16'h0000;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h00000000;
            ctrl <= CTRL_RESET;
            rate <= RATE_RESET;
            faults <= 16'h0000;
        end else begin
            prdata <= next_prdata;
            ctrl <= next_ctrl;
            rate <= next_rate;
            faults <= next_faults;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Service edge detection
    logic svc_meta;
    logic svc_sync;
    logic svc_prev;
    logic next_svc_meta;
    logic next_svc_sync;
    logic next_svc_prev;
    logic service_event;

    // Two flops against metastability; the edge is taken only behind both
    always_comb begin
        next_svc_meta = service_input;
        next_svc_sync = svc_meta;
        next_svc_prev = svc_sync;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            svc_meta <= 1'b0;
            svc_sync <= 1'b0;
            svc_prev <= 1'b0;
        end else begin
            svc_meta <= next_svc_meta;
            svc_sync <= next_svc_sync;
            svc_prev <= next_svc_prev;
        end
    end

    assign service_event = svc_sync && !svc_prev;

    ////////////////////////////////////////////////////////////////////////////
    // Window lengths in oscillator ticks
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] open_len;
    logic [CNT_W-1:0] closed_len;
    logic [CNT_W-1:0] hold_len;
    logic [CNT_W-1:0] init_len;

    // Config writes reshape the live window at once
    always_comb begin
        period = CNT_W'(rate);
        if (ctrl[CTRL_SCALE_BIT]) begin
            period = CNT_W'(rate * SCALE_FACTOR);
        end
        if (ctrl[CTRL_RATIO_BIT]) begin
            open_len = CNT_W'((period * RATIO_NUM) / RATIO_DEN);
        end else begin
            open_len = period / CNT_W'(HALF_DIV);
        end
        closed_len = period - open_len;
        hold_len = period / CNT_W'(HOLD_DIV);
        init_len = CNT_W'(period * INIT_MULT);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog state machine
    wsw_state_t next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] limit;
    logic tick;
    logic restart;
    logic enabled;
    logic rate_bad;
    logic expire;
    logic window_mode;

    // Power good gates the enable; nothing runs without it
    assign enabled = power_good && !ctrl[CTRL_ENABLE_N_BIT];
    assign window_mode = !ctrl[CTRL_TYPE_BIT];
    assign rate_bad = (rate == RATE_W'(0));

    always_comb begin
        case (state)
            WSW_INIT_OPEN: limit = init_len;
            WSW_OPEN: limit = window_mode ? open_len : period;
            WSW_CLOSED: limit = closed_len;
            WSW_FAULT_HOLD: limit = hold_len;
            default: limit = period;
        endcase
    end

    // Zero-length windows still last one tick
    assign expire = tick && (count + CNT_W'(1) >= limit);

    // Re-phased on every restart so windows are whole ticks
    wsw_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .arst_n(arst_n),
        .clear(restart),
        .tick(tick)
    );

    always_comb begin
        next_state = state;
        fault_event = 1'b0;
        case (state)
            WSW_DISABLED: begin
                // Covers rising power good and falling enable-n bit alike
                if (enabled) begin
                    next_state = WSW_INIT_OPEN;
                end
            end
            WSW_INIT_OPEN: begin
                // Service on the expiring tick still counts
                if (service_event) begin
                    next_state = window_mode ? WSW_CLOSED : WSW_OPEN;
                end else if (expire) begin
                    next_state = WSW_FAULT_HOLD;
                    fault_event = 1'b1;
                end
            end
            WSW_OPEN: begin
                if (service_event) begin
                    next_state = window_mode ? WSW_CLOSED : WSW_OPEN;
                end else if (expire) begin
                    next_state = WSW_FAULT_HOLD;
                    fault_event = 1'b1;
                end
            end
            WSW_CLOSED: begin
                if (service_event) begin
                    next_state = WSW_FAULT_HOLD;
                    fault_event = 1'b1;
                end else if (expire) begin
                    next_state = WSW_OPEN;
                end
            end
            WSW_FAULT_HOLD: begin
                // Release of the output restarts the init window
                if (expire) begin
                    next_state = WSW_INIT_OPEN;
                end
            end
            default: next_state = WSW_DISABLED;
        endcase
        if (!enabled) begin
            next_state = WSW_DISABLED;
            fault_event = 1'b0;
        end
    end

    // Any entry into a window, or a service restart, begins a fresh count
    assign restart = (next_state != state) ||
                     (service_event && state == WSW_OPEN && next_state == WSW_OPEN);

    always_comb begin
        next_count = count;
        if (restart) begin
            next_count = '0;
        end else if (tick) begin
            next_count = count + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= WSW_DISABLED;
            count <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Open-drain fault pin: only ever pulls low
    logic next_oe;
    always_comb begin
        next_oe = 1'b0;
        // Zero rate means a broken resistor path: hold the fault
        if (enabled && (next_state == WSW_FAULT_HOLD || rate_bad)) begin
            next_oe = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_output_oe <= 1'b0;
        end else begin
            fault_output_oe <= next_oe;
        end
    end

    assign fault_output_out = 1'b0;
endmodule

// ---- tb/wsw_props.sv ----
// Port checker for the watchdog top
`timescale 1ns/1ps
module wsw_props (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic power_good,
    input wire logic fault_output_out,
    input wire logic fault_output_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////
    a_ready_always: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (psel && penable && !pwrite && paddr > 8'h0C |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_err_mapped: assert property (psel && penable && paddr inside {8'h00, 8'h04, 8'h08, 8'h0C} |-> !pslverr)
        else $error("mapped access refused");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    a_pin_drive_low: assert property (fault_output_out == 1'b0)
        else $error("open drain drives high");
    a_off_released: assert property (!power_good && !$past(power_good) |-> !fault_output_oe)
        else $error("pin pulled while power bad");
    a_hold_min: assert property ($rose(fault_output_oe) |-> (fault_output_oe || !power_good)[*6])
        else $error("fault pulse too short");
    a_hold_bound: assert property ($rose(fault_output_oe) |-> ##[1:400] !fault_output_oe)
        else $error("fault pulse never released");
    a_fault_powered: assert property ($rose(fault_output_oe) |-> $past(power_good))
        else $error("fault raised without power good");
endmodule
bind wsw_top wsw_props wsw_props_inst (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pready, .prdata,
    .pslverr, .power_good, .fault_output_out, .fault_output_oe);

// ---- tb/wsw_mcu.sv ----
// Controller model that services the watchdog
`timescale 1ns/1ps
module wsw_mcu #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic go,
    output logic service_input
);
    // Width scaled down with the windows; the design does not measure it
    int cnt;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            service_input <= 1'b0;
        end else if (go) begin
            cnt <= WIDTH;
            service_input <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else begin
            cnt <= 0;
            service_input <= 1'b0;
        end
    end
endmodule

// ---- tb/window_standard_watchdog_tb.sv ----
// Self-checking bench for the window/standard watchdog
`timescale 1ns/1ps
module window_standard_watchdog_tb import wsw_pkg::*; ;
    localparam int TK = 2;
    localparam int MODES [6] = '{0, 0, 8, 4, 2, 6};
    localparam int GAPS [6] = '{0, 12, 12, 0, 4, 0};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic power_good = 1'b0;
    logic go = 1'b0;
    logic pready, pslverr, service_input, fault_output_out, fault_output_oe, er;
    logic [31:0] prdata, rd;
    // Pull-up holds the pin high when released
    wire logic fault_output_in = !fault_output_oe;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    wsw_top #(.TICK_CYCLES(TK)) wsw_top_inst (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .service_input, .power_good, .fault_output_in, .fault_output_out,
        .fault_output_oe);
    wsw_mcu wsw_mcu_inst (.clk, .arst_n, .go, .service_input);
    ////////////////////////////////////////
    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            give_verdict();
        end
    end
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Sync and tick re-phasing blur edges by a few cycles
    task automatic chk_time(input int got, input int exp, input string what);
        tests_run++;
        if (got > exp + 2 || got < exp - 2) begin
            errors++;
            $display("unexpected at %0t: %s took %0d exp %0d", $time, what, got, exp);
        end
    endtask
    // Waits on pready alone; only the bench timeout ends a stuck transfer
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic meas(input logic lvl, input int lim, output int n);
        n = 0;
        while (fault_output_oe !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic pulse();
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    function automatic int expect_cyc(int ctrl, int p, int gap);
        int closed;
        closed = p - (ctrl[3] ? p * 8 / 9 : p / 2);
        if (!ctrl[1] && gap > 0 && gap < closed * TK) begin
            return 4;
        end
        return p * TK + 4;
    endfunction
    ////////////////////////////////////////
    initial begin
        int n;
        int r;
        int p;
        int e;
        void'($urandom(32'h2754f1c8));
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk_val(rd, 32'h1, "ctrl reset");
        apb(1'b0, RATE_OFS, 32'h0);
        chk_val(rd, 32'h4E20, "rate reset");
        apb(1'b1, STATUS_OFS, 32'hFF);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk_val(rd & 32'h7, 32'h0, "state idle");
        apb(1'b0, 8'h10, 32'h0);
        chk_val({rd[30:0], er}, 32'h1, "unmapped");
        $display("test reset done");
        r = 20 + $urandom % 21;
        apb(1'b1, RATE_OFS, 32'(r));
        apb(1'b1, CTRL_OFS, 32'h0);
        meas(1'b1, 8 * r * TK + 40, n);
        chk_time(n, 8 * r * TK + 40, "gated");
        power_good <= 1'b1;
        meas(1'b1, 5000, n);
        chk_time(n, 8 * r * TK + 4, "init window");
        meas(1'b0, 5000, n);
        chk_time(n, (r / 5) * TK, "hold");
        meas(1'b1, 5000, n);
        // Restart comes from the pin release, with no service sync in the path
        chk_time(n, 8 * r * TK, "reinit");
        meas(1'b0, 5000, n);
        apb(1'b0, FAULTS_OFS, 32'h0);
        chk_val(rd, 32'h2, "fault count");
        $display("test init done");
        for (int i = 0; i < 6; i++) begin
            r = 20 + $urandom % 21;
            p = MODES[i][2] ? r * 5 : r;
            apb(1'b1, CTRL_OFS, 32'h1);
            apb(1'b1, RATE_OFS, 32'(r));
            apb(1'b1, CTRL_OFS, 32'(MODES[i]));
            repeat (10) @(posedge clk);
            pulse();
            if (GAPS[i] > 0) begin
                repeat (GAPS[i] - 1) @(posedge clk);
                pulse();
            end
            e = expect_cyc(MODES[i], p, GAPS[i]);
            meas(1'b1, 5000, n);
            chk_time(n, e, "fault time");
            meas(1'b0, 5000, n);
            chk_time(n, (p / 5) * TK, "fault hold");
            $display("test mode %0d done", i);
        end
        give_verdict();
    end
endmodule
